// File: hw/adc_trig_ctrl.sv
// Trigger select, converter timing sequencer and register slave
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_trig_cfg.svh"
module adc_trig_ctrl #(
    parameter int NUM_INPUTS = 4
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic [10:0] hw_trig_pins,
    output logic             sample_en,
    output logic             convert_en,
    output logic             conv_clk,
    output logic      [1:0]  active_input,
    output logic             data_ready,
    output logic             irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_st_t;

    // ***************************************************************
    // Pin synchronisers: three stages, change accepted on agreement
    // ***************************************************************
    logic [10:0] s1_q, s2_q, s3_q, hw_q, hw_prev_q;
    logic [10:0] hw_d, hw_rise;
    always_comb begin
        hw_d = hw_q;
        for (int i = 0; i < 11; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                hw_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q      <= '0;
            s2_q      <= '0;
            s3_q      <= '0;
            hw_q      <= '0;
            hw_prev_q <= '0;
        end else begin
            s1_q      <= hw_trig_pins;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            hw_q      <= hw_d;
            hw_prev_q <= hw_q;
        end
    end
    // Hardware sources count as events on their rising edge
    assign hw_rise = hw_q & ~hw_prev_q;

    // ***************************************************************
    // Registers
    // ***************************************************************
    logic [31:0]        trig_q, trig_d, time_q, time_d;
    logic [`IRQ_W-1:0]  stat_q, stat_d, mask_q, mask_d, ev;
    logic [2:0]         sw_q, sw_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               irq_q, irq_d;

    // Sequencer state, declared here for the status read
    seq_st_t            st_q, st_d;
    logic [1:0]         in_q, in_d;

    always_comb begin
        trig_d  = trig_q;
        time_d  = time_q;
        mask_d  = mask_q;
        sw_d    = {1'b0, sw_q[`SW_LEVEL_BIT], 1'b0};
        rdata_d = '0;
        // Set wins over a write-one clear in the same cycle
        stat_d  = stat_q;
        if (wr_en && addr == `OFS_IRQ_STATUS) begin
            stat_d = stat_q & ~wdata[`IRQ_W-1:0];
        end
        stat_d = stat_d | ev;
        if (wr_en) begin
            unique case (addr)
                `OFS_TRIG_SEL:  trig_d = wdata & `TRIG_WR_MASK;
                `OFS_TIMING:    time_d = wdata & `TIME_WR_MASK;
                `OFS_IRQ_MASK:  mask_d = wdata[`IRQ_W-1:0];
                `OFS_SW_TRIG:   sw_d   = wdata[2:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                `OFS_TRIG_SEL:   rdata_d = trig_q;
                `OFS_TIMING:     rdata_d = time_q;
                `OFS_IRQ_STATUS: rdata_d = {28'h000_0000, stat_q};
                `OFS_IRQ_MASK:   rdata_d = {28'h000_0000, mask_q};
                `OFS_SW_TRIG:    rdata_d = {30'h0000_0000,
                                            sw_q[`SW_LEVEL_BIT], 1'b0};
                `OFS_RUN_STATUS: rdata_d = {28'h000_0000, in_q, st_q};
                default:         rdata_d = '0;
            endcase
        end
        irq_d = |(stat_d & mask_q);
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            trig_q  <= '0;
            time_q  <= `TIME_RESET;
            stat_q  <= '0;
            mask_q  <= '0;
            sw_q    <= '0;
            rdata_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            trig_q  <= trig_d;
            time_q  <= time_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            sw_q    <= sw_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end
    assign rdata = rdata_q;
    assign irq   = irq_q;

    // ***************************************************************
    // Trigger selection per input
    // ***************************************************************
    logic [NUM_INPUTS-1:0] fire;
    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_mux
        trig_source_mux u_mux (
            .sel      (trig_q[g*`TRIG_STRIDE +: `TRIG_FIELD_W]),
            .sw_edge  (sw_q[`SW_EDGE_BIT]),
            .sw_level (sw_q[`SW_LEVEL_BIT]),
            .scan     (sw_q[`SCAN_BIT]),
            .hw_src   (hw_rise),
            .fire     (fire[g])
        );
    end

    // ***************************************************************
    // Timing fields
    // ***************************************************************
    logic [2:0] eis;
    logic [1:0] res;
    logic [6:0] div;
    logic [9:0] samc;
    assign eis  = time_q[`EIS_LSB +: 3];
    assign res  = time_q[`RES_LSB +: 2];
    assign div  = time_q[`DIV_LSB +: 7];
    assign samc = time_q[`SAMC_LSB +: 10];

    function automatic logic [3:0] conv_clocks(input logic [1:0] r);
        unique case (r)
            adc_trig_pkg::RES_12B: conv_clocks = `CONV_12B;
            adc_trig_pkg::RES_10B: conv_clocks = `CONV_10B;
            adc_trig_pkg::RES_8B:  conv_clocks = `CONV_8B;
            adc_trig_pkg::RES_6B:  conv_clocks = `CONV_6B;
        endcase
    endfunction

    // ***************************************************************
    // Converter clock: half period is div control clocks
    // ***************************************************************
    // Divisor 0 is treated as 1, the smallest documented period
    logic [6:0] dcnt_q, dcnt_d;
    logic       cclk_q, cclk_d, tick;
    always_comb begin
        tick   = 1'b0;
        dcnt_d = dcnt_q + 7'h01;
        cclk_d = cclk_q;
        if (dcnt_q + 7'h01 >= div) begin
            dcnt_d = '0;
            cclk_d = ~cclk_q;
            tick   = cclk_q;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dcnt_q <= '0;
            cclk_q <= 1'b0;
        end else begin
            dcnt_q <= dcnt_d;
            cclk_q <= cclk_d;
        end
    end
    assign conv_clk = cclk_q;

    // ***************************************************************
    // Sample and convert sequencer
    // ***************************************************************
    logic [10:0] cnt_q, cnt_d;
    logic        rdy_q, rdy_d;
    logic        se_q, se_d, ce_q, ce_d;
    logic [3:0]  early;
    logic [1:0]  pick;
    always_comb begin
        pick = '0;
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (fire[i]) begin
                pick = i[1:0];
            end
        end
    end
    assign early = {1'b0, eis} + 4'h1;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        in_d  = in_q;
        rdy_d = 1'b0;
        ev    = '0;
        unique case (st_q)
            ST_IDLE: begin
                if (|fire) begin
                    st_d  = ST_SAMPLE;
                    in_d  = pick;
                    cnt_d = {1'b0, samc} + `SAMPLE_EXTRA;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    cnt_d = cnt_q - 11'h001;
                    if (cnt_q == 11'h001) begin
                        st_d  = ST_CONVERT;
                        cnt_d = {7'h00, conv_clocks(res)};
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    cnt_d = cnt_q - 11'h001;
                    // Early data-ready; counts past the length never match
                    if (cnt_q == {7'h00, early}) begin
                        rdy_d = 1'b1;
                        ev[in_q] = 1'b1;
                    end
                    if (cnt_q == 11'h001) begin
                        st_d = ST_IDLE;
                    end
                end
            end
        endcase
        se_d = (st_d == ST_SAMPLE);
        ce_d = (st_d == ST_CONVERT);
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q  <= ST_IDLE;
            cnt_q <= '0;
            in_q  <= '0;
            rdy_q <= 1'b0;
            se_q  <= 1'b0;
            ce_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            in_q  <= in_d;
            rdy_q <= rdy_d;
            se_q  <= se_d;
            ce_q  <= ce_d;
        end
    end
    // Phase flags registered so the pins never glitch on a state decode
    assign sample_en    = se_q;
    assign convert_en   = ce_q;
    assign active_input = in_q;
    assign data_ready   = rdy_q;

    // ***************************************************************
    // Checks
    // ***************************************************************
    reset_time_a: assert property (@(posedge core_clk)
        $fell(srst) |-> time_q == `TIME_RESET)
        else $error("timing register reset value wrong");
    trig_mask_a: assert property (@(posedge core_clk)
        disable iff (srst) (trig_q & ~`TRIG_WR_MASK) == '0)
        else $error("unimplemented trigger bits set");
    time_mask_a: assert property (@(posedge core_clk)
        disable iff (srst) (time_q & ~`TIME_WR_MASK) == '0)
        else $error("unimplemented timing bits set");
    start_seq_a: assert property (@(posedge core_clk)
        disable iff (srst) st_q == ST_IDLE && |fire |=> st_q == ST_SAMPLE)
        else $error("trigger did not start sampling");
    sample_load_a: assert property (@(posedge core_clk)
        disable iff (srst) st_q == ST_IDLE && |fire |=>
        cnt_q == {1'b0, $past(samc)} + `SAMPLE_EXTRA)
        else $error("sample length not samc plus two");
    conv_load_a: assert property (@(posedge core_clk)
        disable iff (srst) st_q == ST_SAMPLE ##1 st_q == ST_CONVERT |->
        cnt_q == {7'h00, conv_clocks(res)})
        else $error("conversion length wrong");
    none_code_a: assert property (@(posedge core_clk)
        disable iff (srst) trig_q == '0 |-> fire == '0)
        else $error("disabled inputs fired");
    early_rdy_a: assert property (@(posedge core_clk)
        disable iff (srst) st_q == ST_CONVERT && tick &&
        cnt_q == {7'h00, early} |=> data_ready)
        else $error("data ready not at early point");
    clk_half_a: assert property (@(posedge core_clk)
        disable iff (srst) $changed(cclk_q) && div > 7'h01 |=>
        !$changed(cclk_q))
        else $error("converter clock half period too short");
    reserved_a: assert property (@(posedge core_clk)
        disable iff (srst) trig_q[4:0] > 5'h0C |-> !fire[0])
        else $error("reserved code fired");
    irq_level_a: assert property (@(posedge core_clk)
        disable iff (srst) |(stat_q & mask_q) |=> irq || $past(wr_en))
        else $error("interrupt not raised");
    cover_sample: cover property (@(posedge core_clk) st_q == ST_SAMPLE);
    cover_ready:  cover property (@(posedge core_clk) data_ready);
    cover_irq:    cover property (@(posedge core_clk) irq);
endmodule
`default_nettype wire

// File: hw/adc_trig_cfg.svh
// Register map, field positions, reset values and timing constants
`ifndef ADC_TRIG_CFG_SVH
`define ADC_TRIG_CFG_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define OFS_TRIG_SEL    8'h00
`define OFS_TIMING      8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_SW_TRIG     8'h10
`define OFS_RUN_STATUS  8'h14

// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define TRIG_FIELD_W    5
`define TRIG_STRIDE     8
`define TRIG_WR_MASK    32'h1F1F_1F1F
`define TIME_WR_MASK    32'h1F7F_03FF
`define TIME_RESET      32'h0300_0000
`define EIS_LSB         26
`define RES_LSB         24
`define DIV_LSB         16
`define SAMC_LSB        0
`define SW_EDGE_BIT     0
`define SW_LEVEL_BIT    1
`define SCAN_BIT        2
`define IRQ_W           4

// ***************************************************************
// Timing
// ***************************************************************
`define SAMPLE_EXTRA    11'h002
`define CONV_12B        4'hD
`define CONV_10B        4'hB
`define CONV_8B         4'h9
`define CONV_6B         4'h7

`endif

// File: hw/adc_trig_pkg.sv
// Types shared by the trigger and timing control
package adc_trig_pkg;
    typedef enum logic [4:0] {
        TRG_NONE     = 5'h00,
        TRG_SW_EDGE  = 5'h01,
        TRG_SW_LEVEL = 5'h02,
        TRG_SCAN     = 5'h03,
        TRG_EXT_EXTERNAL_INTERRUPT_ZERO = 5'h04,
        TRG_TIMER1   = 5'h05,
        TRG_TIMER3   = 5'h06,
        TRG_TIMER5   = 5'h07,
        TRG_OC1      = 5'h08,
        TRG_OC3      = 5'h09,
        TRG_OC5      = 5'h0A,
        TRG_CMP1     = 5'h0B,
        TRG_CMP2     = 5'h0C
    } trig_code_t;

    typedef enum logic [1:0] {
        RES_6B  = 2'h0,
        RES_8B  = 2'h1,
        RES_10B = 2'h2,
        RES_12B = 2'h3
    } res_sel_t;
endpackage

// File: hw/trig_source_mux.sv
// Trigger source decode for one analog input
`timescale 1ns/100ps
`default_nettype none
module trig_source_mux (
    input  wire logic [4:0]  sel,
    input  wire logic        sw_edge,
    input  wire logic        sw_level,
    input  wire logic        scan,
    input  wire logic [10:0] hw_src,
    output logic             fire
);
    // hw_src: 0 ext int, 1 tmr1, 2 tmr3, 3 timer_five, 4..6 oc1/3/5, 7..8 cmp1/2
    always_comb begin
        fire = 1'b0;
        // Reserved codes fall through to no trigger
        unique case (sel)
            adc_trig_pkg::TRG_SW_EDGE:  fire = sw_edge;
            adc_trig_pkg::TRG_SW_LEVEL: fire = sw_level;
            adc_trig_pkg::TRG_SCAN:     fire = scan;
            adc_trig_pkg::TRG_EXT_EXTERNAL_INTERRUPT_ZERO: fire = hw_src[0];
            adc_trig_pkg::TRG_TIMER1:   fire = hw_src[1];
            adc_trig_pkg::TRG_TIMER3:   fire = hw_src[2];
            adc_trig_pkg::TRG_TIMER5:   fire = hw_src[3];
            adc_trig_pkg::TRG_OC1:      fire = hw_src[4];
            adc_trig_pkg::TRG_OC3:      fire = hw_src[5];
            adc_trig_pkg::TRG_OC5:      fire = hw_src[6];
            adc_trig_pkg::TRG_CMP1:     fire = hw_src[7];
            adc_trig_pkg::TRG_CMP2:     fire = hw_src[8];
            default:                    fire = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: tb/trig_source_model.sv
// Stand-in for the on-chip trigger sources feeding the hardware trigger pins
`timescale 1ns/100ps
`default_nettype none
module trig_source_model (
    input  wire logic        core_clk,
    output logic      [10:0] hw_trig_pins
);
    initial hw_trig_pins = 11'h000;

    // Held three cycles so the input synchroniser cannot miss the edge
    task automatic pulse(input int idx);
        @(posedge core_clk);
        hw_trig_pins[idx] <= 1'b1;
        repeat (3) @(posedge core_clk);
        hw_trig_pins[idx] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_adc_trig_ctrl.sv
// Self-checking bench for the trigger select and converter timing block
`timescale 1ns/100ps
`default_nettype none
`include "adc_trig_cfg.svh"
module tb_adc_trig_ctrl;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wdata    = 32'h0000_0000;
    logic        wr_en    = 1'b0;
    logic        rd_en    = 1'b0;
    logic [31:0] rdata;
    logic [10:0] hw_trig_pins;
    logic        sample_en;
    logic        convert_en;
    logic        conv_clk;
    logic [1:0]  active_input;
    logic        data_ready;
    logic        irq;
    logic [31:0] v;
    logic [31:0] exp_v;
    logic        hit;
    logic        cc_p = 1'b0;
    logic        se_p = 1'b0;
    logic        ce_p = 1'b0;
    logic        dr_seen = 1'b0;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          n_samp, n_conv, n_after, n_dr, n_busy, per, cyc, last_fall;

    always #5 core_clk = ~core_clk;

    adc_trig_ctrl adc_trig_ctrl_i (
        .core_clk     (core_clk),
        .srst         (srst),
        .addr         (addr),
        .wdata        (wdata),
        .wr_en        (wr_en),
        .rd_en        (rd_en),
        .rdata        (rdata),
        .hw_trig_pins (hw_trig_pins),
        .sample_en    (sample_en),
        .convert_en   (convert_en),
        .conv_clk     (conv_clk),
        .active_input (active_input),
        .data_ready   (data_ready),
        .irq          (irq)
    );

    trig_source_model trig_source_model_i (
        .core_clk     (core_clk),
        .hw_trig_pins (hw_trig_pins)
    );

    // ***************************************************************
    // Converter clock monitor
    // ***************************************************************
    // A tick is counted against the phase that was active before it,
    // so a phase change on the tick edge itself is not lost
    always @(posedge core_clk) begin
        cyc++;
        if (cc_p === 1'b1 && conv_clk === 1'b0) begin
            per = cyc - last_fall;
            last_fall = cyc;
            if (se_p === 1'b1) n_samp++;
            if (ce_p === 1'b1) n_conv++;
            if (ce_p === 1'b1 && dr_seen) n_after++;
        end
        if (data_ready === 1'b1) begin
            n_dr++;
            dr_seen = 1'b1;
        end
        if (sample_en === 1'b1) n_busy++;
        cc_p = conv_clk;
        se_p = sample_en;
        ce_p = convert_en;
    end

    // ***************************************************************
    // Tasks
    // ***************************************************************
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        // One idle edge so a following call never re-drives the strobe
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(negedge core_clk);
        d = rdata;
        @(posedge core_clk);
    endtask

    task automatic clr;
        @(negedge core_clk);
        n_samp = 0;
        n_conv = 0;
        n_after = 0;
        n_dr = 0;
        n_busy = 0;
        dr_seen = 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_start(output logic h);
        h = 1'b0;
        repeat (40) begin
            @(negedge core_clk);
            if (sample_en === 1'b1 || convert_en === 1'b1) begin
                h = 1'b1;
                break;
            end
        end
        @(posedge core_clk);
    endtask

    task automatic wait_idle;
        int k;
        k = 0;
        while (k < 5000 && (sample_en !== 1'b0 || convert_en !== 1'b0)) begin
            @(negedge core_clk);
            k++;
        end
        chk("run_ends", 32'(k < 5000), 32'h0000_0001);
        repeat (2) @(posedge core_clk);
    endtask

    // One software-edge conversion on input 0 with the given timing
    task automatic conv_row(input logic [1:0] res, input logic [2:0] eis,
                            input logic [9:0] samc, input logic [6:0] div);
        int nc;
        nc = (res == 2'h3) ? 13 : (res == 2'h2) ? 11 : (res == 2'h1) ? 9 : 7;
        wr(`OFS_TIMING, {3'h0, eis, res, 1'b0, div, 6'h00, samc});
        clr;
        wr(`OFS_SW_TRIG, 32'h0000_0001);
        wait_start(hit);
        chk("start", 32'(hit), 32'h0000_0001);
        wait_idle;
        chk("samp_ticks", n_samp, 32'(samc) + 2);
        chk("conv_ticks", n_conv, nc);
        chk("early_ticks", n_after, 32'(eis));
        chk("dr_pulses", n_dr, 32'h0000_0001);
        chk("tick_period", per, 32'(div) * 2);
    endtask

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(`OFS_TRIG_SEL, v);
        chk("trig_reset", v, 32'h0000_0000);
        rd(`OFS_TIMING, v);
        chk("time_reset", v, 32'h0300_0000);
        wr(`OFS_TRIG_SEL, 32'hFFFF_FFFF);
        rd(`OFS_TRIG_SEL, v);
        chk("trig_mask", v, 32'h1F1F_1F1F);
        wr(`OFS_TIMING, 32'hFFFF_FFFF);
        rd(`OFS_TIMING, v);
        chk("time_mask", v, 32'h1F7F_03FF);
        rd(8'hFC, v);
        chk("unmapped", v, 32'h0000_0000);
        wr(`OFS_IRQ_MASK, 32'h0000_0000);
        wr(`OFS_TRIG_SEL, 32'h0000_0001);
        // Early select kept in the legal range per resolution
        conv_row(2'h3, 3'h7, 10'h000, 7'h01);
        conv_row(2'h2, 3'h6, 10'h001, 7'h02);
        conv_row(2'h1, 3'h5, 10'h005, 7'h01);
        conv_row(2'h0, 3'h3, 10'h003, 7'h03);
        conv_row(2'h3, 3'h0, 10'h3FF, 7'h01);
        conv_row(2'h3, 3'h1, 10'h000, 7'h7F);
        // Interrupt: status sticky, mask gates the line, write one clears
        rd(`OFS_IRQ_STATUS, v);
        chk("irq_status", v, 32'h0000_0001);
        chk("irq_masked", 32'(irq), 32'h0000_0000);
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        @(negedge core_clk);
        chk("irq_on", 32'(irq), 32'h0000_0001);
        @(posedge core_clk);
        wr(`OFS_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(negedge core_clk);
        chk("irq_off", 32'(irq), 32'h0000_0000);
        @(posedge core_clk);
        rd(`OFS_IRQ_STATUS, v);
        chk("irq_clr", v, 32'h0000_0000);
        // Hardware sources on input 1, fastest timing
        wr(`OFS_TIMING, 32'h0001_0000);
        for (int c = 4; c <= 12; c++) begin
            wr(`OFS_TRIG_SEL, 32'(c) << 8);
            trig_source_model_i.pulse(c - 4);
            wait_start(hit);
            chk("hw_trig", 32'(hit), 32'h0000_0001);
            chk("hw_input", 32'(active_input), 32'h0000_0001);
            wait_idle;
        end
        // Disabled and reserved codes never start a run
        for (int i = 0; i < 3; i++) begin
            exp_v = (i == 0) ? 32'h0000_0000 :
                    (i == 1) ? 32'h0000_0D00 : 32'h0000_1F00;
            wr(`OFS_TRIG_SEL, exp_v);
            rd(`OFS_TRIG_SEL, v);
            chk("bad_code_rb", v, exp_v);
            clr;
            wr(`OFS_SW_TRIG, 32'h0000_0001);
            for (int p = 0; p <= 8; p++) trig_source_model_i.pulse(p);
            repeat (10) @(posedge core_clk);
            chk("no_trig", n_busy, 32'h0000_0000);
        end
        // Level software trigger keeps retriggering while held
        wr(`OFS_TRIG_SEL, 32'h0002_0000);
        clr;
        wr(`OFS_SW_TRIG, 32'h0000_0002);
        repeat (80) @(posedge core_clk);
        wr(`OFS_SW_TRIG, 32'h0000_0000);
        wait_idle;
        chk("level_rerun", 32'(n_dr >= 2), 32'h0000_0001);
        // Scan trigger on input 3
        wr(`OFS_TRIG_SEL, 32'h0300_0000);
        wr(`OFS_SW_TRIG, 32'h0000_0004);
        wait_start(hit);
        chk("scan_trig", 32'(hit), 32'h0000_0001);
        chk("scan_input", 32'(active_input), 32'h0000_0003);
        wait_idle;
        // Idle state with the last input kept
        rd(`OFS_RUN_STATUS, v);
        chk("run_status", v, 32'h0000_000C);
        // Two inputs fire together: lowest index runs
        wr(`OFS_TRIG_SEL, 32'h0100_0001);
        wr(`OFS_SW_TRIG, 32'h0000_0001);
        wait_start(hit);
        chk("prio_input", 32'(active_input), 32'h0000_0000);
        wait_idle;
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_of_test;
    end
endmodule
`default_nettype wire
